// *** itf_defs.svh ***
// Constants for the input terminal function mapper
// Operation
// - Each of eight terminals takes any option code from its own function setting.
// - Each terminal has its own polarity setting, applied before decoding.
// - Option 01 active puts the drive in run mode turning in reverse.
// - Options 02 to 05 form a four-bit speed select, 02 the LSB.
// - Option 06 active runs the motor at the jog frequency.
// - Option 07 active applies DC injection braking during deceleration.
// - Option 08 active selects the second motor parameter set.
// - Option 09 active selects the second-stage ramp values.
// - Option 11 active switches motor output off so the motor coasts.
// - Option 12 rising edge latches a trip with error code E12 until reset.
// - Option 13 active at power-up blocks resuming an earlier run command.
// - Option 14 rising edge marks bypass running and suppresses motor output.
// - Bypass falling edge: wait retry delay, match frequency, then resume run.
// - Option 15 active rejects all parameter changes.
// - Option 16 routes analog source by routing parameter; inactive picks main voltage.
// - Option 17 active selects the third motor parameter set.
// - Option 18 activation clears trip, turns output off, asserts power-up reset.
// - Option 20 activation starts motor rotation in three-wire control.
// - A terminal carrying the reset function cannot be active low.
// - One option on several terminals is active when any of them is.
// - Terminals default to active high; active low inverts the input.
`ifndef ITF_DEFS_SVH
`define ITF_DEFS_SVH

// ==========================================================
// Register byte offsets
`define ITF_REG_FUNC_LO 8'h00
`define ITF_REG_FUNC_HI 8'h04
`define ITF_REG_POL 8'h08
`define ITF_REG_ROUTE 8'h0C
`define ITF_REG_JOG 8'h10
`define ITF_REG_BYP_DLY 8'h14
`define ITF_REG_STATUS 8'h18
`define ITF_REG_ERROR 8'h1C

// ==========================================================
// Reset values
`define ITF_FUNC_LO_RST 32'h0B061012
`define ITF_FUNC_HI_RST 32'h01020309
`define ITF_POL_RST 8'h00
`define ITF_ROUTE_RST 2'h0
`define ITF_JOG_RST 16'h0000
`define ITF_BYP_DLY_RST 16'h0000

// ==========================================================
// Option codes and decoding
`define ITF_OPT_REV 5'h01
`define ITF_OPT_SPD0 5'h02
`define ITF_OPT_JOG 5'h06
`define ITF_OPT_DCB 5'h07
`define ITF_OPT_SET2 5'h08
`define ITF_OPT_RAMP2 5'h09
`define ITF_OPT_COAST 5'h0B
`define ITF_OPT_TRIP 5'h0C
`define ITF_OPT_GUARD 5'h0D
`define ITF_OPT_BYPASS 5'h0E
`define ITF_OPT_LOCK 5'h0F
`define ITF_OPT_ANALOG 5'h10
`define ITF_OPT_THIRD_MOTOR_SELECT 5'h11
`define ITF_OPT_RESET 5'h12
`define ITF_OPT_START 5'h14
`define ITF_OPT_MAX 8'h14
`define ITF_OPT_DEFINED 21'h17FBFE
`define ITF_ERR_OUTSIDE 8'h0C

// ==========================================================
// Timing
`define ITF_CLK_PERIOD_NS 4
`define ITF_DELAY_UNIT_NS 1000000
`define ITF_SYNC_SETTLE 2'h3

// ==========================================================
// Bus responses
`define ITF_RESP_OKAY 2'h0
`define ITF_RESP_SLVERR 2'h2

`endif

// *** itf_mapper.sv ***
// Input terminal function mapper with AXI4-Lite configuration slave
`timescale 1ns/1ps
`include "itf_defs.svh"

module itf_mapper
  import itf_pkg::*;
#(
  parameter int TICK_CYCLES = `ITF_DELAY_UNIT_NS / `ITF_CLK_PERIOD_NS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] term_in,
  input wire logic run_cmd_in,
  input wire logic decel_in,
  input wire logic freq_match_done,
  output itf_cmd_t cmd,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ==========================================================
  // Functions

  // Reset-function terminals are forced active high
  function automatic logic [7:0] itf_pol_eff(
    input logic [7:0] pol,
    input logic [7:0][7:0] fn
  );
    logic [7:0] p;
    p = pol;
    for (int t = 0; t < 8; t++)
    begin
      if (fn[t] == {3'h0, `ITF_OPT_RESET})
      begin
        p[t] = 1'b0;
      end
    end
    return p;
  endfunction

  function automatic logic [20:0] itf_decode(
    input logic [7:0] act,
    input logic [7:0][7:0] fn
  );
    logic [20:0] v;
    v = 21'h000000;
    for (int t = 0; t < 8; t++)
    begin
      if (act[t] && fn[t] <= `ITF_OPT_MAX)
      begin
        v[fn[t][4:0]] = 1'b1;
      end
    end
    return v & `ITF_OPT_DEFINED;
  endfunction

  function automatic logic [31:0] itf_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Registers sit on word boundaries, so the two byte-lane bits are not decoded
  function automatic logic itf_hit(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return addr[7:2] == off[7:2];
  endfunction

  // ==========================================================
  // State

  itf_state_t s_q;
  itf_state_t s_d;
  logic [7:0] pol_eff;
  logic [20:0] rise;
  logic [20:0] fall;
  logic lock;
  logic [31:0] jog_wr;
  logic [31:0] dly_wr;

  assign pol_eff = itf_pol_eff(s_q.pol, s_q.fn);
  // Edges only count once the first samples after reset are valid
  assign rise = s_q.armed ? (s_q.fv & ~s_q.fv_prev) : 21'h000000;
  assign fall = s_q.armed ? (~s_q.fv & s_q.fv_prev) : 21'h000000;
  assign lock = s_q.fv[`ITF_OPT_LOCK];
  // The 16-bit registers merge as a full word and keep only the low half
  assign jog_wr = itf_merge({16'h0000, s_q.jog}, s_q.wdata, s_q.wstrb);
  assign dly_wr = itf_merge({16'h0000, s_q.dly}, s_q.wdata, s_q.wstrb);

  always_comb
  begin
    s_d = s_q;
    // ========================================================
    // Terminal sampling and decoding
    s_d.sync1 = term_in;
    s_d.sync2 = s_q.sync1;
    s_d.fv = itf_decode(s_q.sync2 ^ pol_eff, s_q.fn);
    s_d.fv_prev = s_q.fv;
    if (s_q.settle != `ITF_SYNC_SETTLE)
    begin
      s_d.settle = s_q.settle + 2'h1;
    end
    else if (!s_q.armed)
    begin
      s_d.armed = 1'b1;
      s_d.guard = s_q.fv[`ITF_OPT_GUARD] & run_cmd_in;
    end
    if (!run_cmd_in)
    begin
      s_d.guard = 1'b0;
    end

    // ========================================================
    // Trip, reset and start events
    // A new trip edge beats a simultaneous reset edge
    s_d.trip = (s_q.trip & ~rise[`ITF_OPT_RESET]) | rise[`ITF_OPT_TRIP];
    s_d.pur = rise[`ITF_OPT_RESET];
    s_d.start = rise[`ITF_OPT_START];
    if (rise[`ITF_OPT_RESET])
    begin
      // Power-up reset re-runs the start-up guard capture
      s_d.settle = 2'h0;
      s_d.armed = 1'b0;
    end

    // ========================================================
    // Bypass handover
    case (s_q.byp)
      BYP_IDLE:
      begin
        if (rise[`ITF_OPT_BYPASS])
        begin
          s_d.byp = BYP_HOLD;
        end
      end
      BYP_HOLD:
      begin
        if (fall[`ITF_OPT_BYPASS])
        begin
          s_d.byp = BYP_WAIT;
          s_d.tick = 20'h00000;
          s_d.ms = 16'h0000;
        end
      end
      BYP_WAIT:
      begin
        // A new bypass rise hands the motor back to the supply and drops the count
        if (rise[`ITF_OPT_BYPASS])
        begin
          s_d.byp = BYP_HOLD;
        end
        else if (s_q.ms >= s_q.dly)
        begin
          s_d.byp = BYP_MATCH;
        end
        else if (s_q.tick == 20'(TICK_CYCLES - 1))
        begin
          s_d.tick = 20'h00000;
          s_d.ms = s_q.ms + 16'h0001;
        end
        else
        begin
          s_d.tick = s_q.tick + 20'h00001;
        end
      end
      BYP_MATCH:
      begin
        if (rise[`ITF_OPT_BYPASS])
        begin
          s_d.byp = BYP_HOLD;
        end
        else if (freq_match_done)
        begin
          s_d.byp = BYP_IDLE;
        end
      end
      default:
      begin
        s_d.byp = BYP_IDLE;
      end
    endcase

    // ========================================================
    // AXI4-Lite write path
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `ITF_RESP_OKAY;
      if (lock)
      begin
        s_d.bresp = `ITF_RESP_SLVERR;
      end
      else if (itf_hit(s_q.awaddr, `ITF_REG_FUNC_LO))
      begin
        s_d.fn[3:0] = itf_merge(s_q.fn[3:0], s_q.wdata, s_q.wstrb);
      end
      else if (itf_hit(s_q.awaddr, `ITF_REG_FUNC_HI))
      begin
        s_d.fn[7:4] = itf_merge(s_q.fn[7:4], s_q.wdata, s_q.wstrb);
      end
      else if (itf_hit(s_q.awaddr, `ITF_REG_POL))
      begin
        s_d.pol = s_q.wstrb[0] ? s_q.wdata[7:0] : s_q.pol;
      end
      else if (itf_hit(s_q.awaddr, `ITF_REG_ROUTE))
      begin
        s_d.route = s_q.wstrb[0] ? s_q.wdata[1:0] : s_q.route;
      end
      else if (itf_hit(s_q.awaddr, `ITF_REG_JOG))
      begin
        s_d.jog = jog_wr[15:0];
      end
      else if (itf_hit(s_q.awaddr, `ITF_REG_BYP_DLY))
      begin
        s_d.dly = dly_wr[15:0];
      end
      else
      begin
        // Status and error words are read-only; holes are unmapped
        s_d.bresp = `ITF_RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // ========================================================
    // AXI4-Lite read path
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `ITF_RESP_OKAY;
      // Decoded as the address is taken; the word then stands until rready
      s_d.rdata = 32'h00000000;
      if (itf_hit(s_axi_araddr, `ITF_REG_FUNC_LO))
      begin
        s_d.rdata = s_q.fn[3:0];
      end
      else if (itf_hit(s_axi_araddr, `ITF_REG_FUNC_HI))
      begin
        s_d.rdata = s_q.fn[7:4];
      end
      else if (itf_hit(s_axi_araddr, `ITF_REG_POL))
      begin
        s_d.rdata = {24'h000000, pol_eff};
      end
      else if (itf_hit(s_axi_araddr, `ITF_REG_ROUTE))
      begin
        s_d.rdata = {30'h00000000, s_q.route};
      end
      else if (itf_hit(s_axi_araddr, `ITF_REG_JOG))
      begin
        s_d.rdata = {16'h0000, s_q.jog};
      end
      else if (itf_hit(s_axi_araddr, `ITF_REG_BYP_DLY))
      begin
        s_d.rdata = {16'h0000, s_q.dly};
      end
      else if (itf_hit(s_axi_araddr, `ITF_REG_STATUS))
      begin
        s_d.rdata = {19'h00000, lock, s_q.byp, s_q.guard, s_q.trip, s_q.sync2};
      end
      else if (itf_hit(s_axi_araddr, `ITF_REG_ERROR))
      begin
        s_d.rdata = {24'h000000, s_q.trip ? `ITF_ERR_OUTSIDE : 8'h00};
      end
      else
      begin
        s_d.rresp = `ITF_RESP_SLVERR;
      end
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.fn[3:0] <= `ITF_FUNC_LO_RST;
      s_q.fn[7:4] <= `ITF_FUNC_HI_RST;
      s_q.pol <= `ITF_POL_RST;
      s_q.route <= `ITF_ROUTE_RST;
      s_q.jog <= `ITF_JOG_RST;
      s_q.dly <= `ITF_BYP_DLY_RST;
      s_q.byp <= BYP_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  assign cmd.reverse_run = s_q.fv[`ITF_OPT_REV];
  assign cmd.jog_run = s_q.fv[`ITF_OPT_JOG];
  assign cmd.jog_freq = s_q.jog;
  assign cmd.speed_sel = s_q.fv[`ITF_OPT_SPD0 +: 4];
  assign cmd.dc_brake_apply = s_q.fv[`ITF_OPT_DCB] & decel_in;
  // Third set wins if both selects are on at once
  assign cmd.motor_set = s_q.fv[`ITF_OPT_THIRD_MOTOR_SELECT] ? 2'h2 : {1'b0, s_q.fv[`ITF_OPT_SET2]};
  assign cmd.second_ramp_select = s_q.fv[`ITF_OPT_RAMP2];
  assign cmd.coast_stop = s_q.fv[`ITF_OPT_COAST];
  assign cmd.motor_output_enable = !s_q.fv[`ITF_OPT_COAST] && !s_q.trip && !s_q.pur
    && !s_q.fv[`ITF_OPT_RESET] && s_q.byp != BYP_HOLD && s_q.byp != BYP_WAIT;
  assign cmd.trip_latched = s_q.trip;
  assign cmd.error_code = s_q.trip ? `ITF_ERR_OUTSIDE : 8'h00;
  assign cmd.power_up_guard_hold = s_q.guard;
  assign cmd.bypass_active = s_q.byp != BYP_IDLE;
  assign cmd.freq_match_req = s_q.byp == BYP_MATCH;
  assign cmd.parameter_lock = lock;
  // analog_sel bit 0 main voltage, bit 1 current, bit 2 second voltage
  assign cmd.analog_sel = !s_q.fv[`ITF_OPT_ANALOG] ? 3'h1
    : (s_q.route == 2'h0 ? 3'h2 : (s_q.route == 2'h1 ? 3'h4 : 3'h0));
  assign cmd.power_up_reset = s_q.pur;
  assign cmd.three_wire_begin = s_q.start;

endmodule

// *** itf_mapper_sva.sv ***
// Assertion checker for the terminal function mapper
`timescale 1ns/1ps
module itf_mapper_sva
  import itf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic decel_in,
  input wire logic freq_match_done,
  input wire itf_cmd_t cmd
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Trip and reset
  AST_ERR_CODE: assert property (cmd.error_code == (cmd.trip_latched ? 8'h0C : 8'h00))
    else $error("error code does not follow trip");
  AST_TRIP_CLEAR: assert property ($fell(cmd.trip_latched) |-> cmd.power_up_reset)
    else $error("trip cleared without reset");
  AST_RST_OFF: assert property (cmd.power_up_reset |-> !cmd.motor_output_enable)
    else $error("output on during reset pulse");
  AST_RST_PULSE: assert property (cmd.power_up_reset |=> !cmd.power_up_reset)
    else $error("reset pulse too long");
  // ==========
  // Run control
  AST_COAST: assert property (cmd.coast_stop |-> !cmd.motor_output_enable)
    else $error("output on while coasting");
  AST_START: assert property (cmd.three_wire_begin |=> !cmd.three_wire_begin)
    else $error("start pulse too long");
  AST_DCB: assert property (cmd.dc_brake_apply |-> decel_in)
    else $error("braking outside deceleration");
  AST_ANALOG: assert property ($onehot0(cmd.analog_sel))
    else $error("more than one analog source");
  // ==========
  // Bypass
  AST_BYP_OFF: assert property (cmd.bypass_active && !cmd.freq_match_req |-> !cmd.motor_output_enable)
    else $error("output on during bypass");
  AST_MATCH_END: assert property (cmd.freq_match_req && freq_match_done |=> !cmd.freq_match_req)
    else $error("match request not ended");
  cover property (cmd.trip_latched);
  cover property (cmd.freq_match_req && freq_match_done);
  cover property (cmd.three_wire_begin);
  cover property (cmd.parameter_lock);
endmodule

bind itf_mapper itf_mapper_sva i_itf_mapper_sva (.aclk(aclk), .aresetn(aresetn),
  .decel_in(decel_in), .freq_match_done(freq_match_done), .cmd(cmd));

// *** itf_pkg.sv ***
// Types for the input terminal function mapper
package itf_pkg;

  typedef enum logic [1:0] {BYP_IDLE, BYP_HOLD, BYP_WAIT, BYP_MATCH} itf_byp_t;

  typedef struct packed {
    logic reverse_run;
    logic jog_run;
    logic [15:0] jog_freq;
    logic [3:0] speed_sel;
    logic dc_brake_apply;
    logic [1:0] motor_set;
    logic second_ramp_select;
    logic coast_stop;
    logic motor_output_enable;
    logic trip_latched;
    logic [7:0] error_code;
    logic power_up_guard_hold;
    logic bypass_active;
    logic freq_match_req;
    logic parameter_lock;
    logic [2:0] analog_sel;
    logic power_up_reset;
    logic three_wire_begin;
  } itf_cmd_t;

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [20:0] fv;
    logic [20:0] fv_prev;
    logic [1:0] settle;
    logic armed;
    logic [7:0][7:0] fn;
    logic [7:0] pol;
    logic [1:0] route;
    logic [15:0] jog;
    logic [15:0] dly;
    logic trip;
    logic guard;
    logic pur;
    logic start;
    itf_byp_t byp;
    logic [19:0] tick;
    logic [15:0] ms;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } itf_state_t;

endpackage

// *** itf_switch_model.sv ***
// Terminal switch model standing in for the field contacts
`timescale 1ns/1ps
module itf_switch_model
(
  input wire logic aclk,
  input wire logic [7:0] level,
  output logic [7:0] term_in
);
  // ==========
  // Contacts
  // Contacts change just after an edge, never in step with the clock
  initial term_in = 8'h00;
  always @(posedge aclk)
    term_in <= #1 level;
endmodule

// *** tb_input_terminal_function_mapper.sv ***
// Self-checking bench for the terminal function mapper
`timescale 1ns/1ps
`include "itf_defs.svh"
`define CHK(a,e) begin compares++; if ((a) !== (e)) begin error_cnt++; $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_input_terminal_function_mapper;
  import itf_pkg::*;
  localparam logic [27:0] BASE = 28'h1000001;
  localparam logic [27:0] FULL = 28'hFFFFFFF;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] lvl = 8'h00;
  logic [7:0] term_in;
  logic run_cmd_in = 1'b0;
  logic decel_in = 1'b0;
  logic freq_match_done = 1'b0;
  itf_cmd_t cmd;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rt;
  int error_cnt = 0;
  int compares = 0;
  int pur_n = 0;
  int n;
  logic [33:0] rq[$];
  logic [55:0] vq[$];
  logic smp = 1'b0;
  logic [33:0] x;
  logic [55:0] y;
  logic [63:0] f;
  logic [7:0] p, act, pe;
  logic dec;
  logic [27:0] view;
  assign view = {cmd.power_up_guard_hold, cmd.freq_match_req, cmd.bypass_active,
    cmd.motor_output_enable, cmd.trip_latched, cmd.error_code, cmd.reverse_run, cmd.jog_run,
    cmd.speed_sel, cmd.dc_brake_apply, cmd.motor_set, cmd.second_ramp_select,
    cmd.coast_stop, cmd.parameter_lock, cmd.analog_sel};

  always #2 aclk = ~aclk;

  itf_switch_model i_itf_switch_model (.aclk(aclk), .level(lvl), .term_in(term_in));
  itf_mapper #(.TICK_CYCLES(4)) i_itf_mapper (.aclk(aclk), .aresetn(aresetn),
    .term_in(term_in), .run_cmd_in(run_cmd_in), .decel_in(decel_in),
    .freq_match_done(freq_match_done), .cmd(cmd), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  // ==========
  // Tasks
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    print_verdict();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    int k;
    logic aw, w;
    k = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    rq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      aw = aw && !awready;
      w = w && !wready;
      awvalid <= aw;
      wvalid <= w;
    end
    while (!bvalid && k < 50);
    bready <= 1'b0;
    if (k >= 50) hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    k = 0;
    @(posedge aclk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && k < 50);
    rready <= 1'b0;
    if (k >= 50) hang();
  endtask

  task automatic pins(input logic [7:0] v);
    @(posedge aclk);
    lvl <= v;
    cyc(6);
  endtask

  task automatic expv(input logic [27:0] m, input logic [27:0] e);
    @(posedge aclk);
    vq.push_back({m, e});
    smp <= 1'b1;
    @(posedge aclk);
    smp <= 1'b0;
  endtask

  // Reference decoder: OR of every active terminal onto its option
  function automatic logic [27:0] ref_view(input logic [7:0] a, input logic [63:0] fc,
    input logic dc, input logic [1:0] r);
    logic [20:0] o;
    logic [1:0] ms;
    logic [2:0] an;
    o = '0;
    for (int t = 0; t < 8; t++)
      if (a[t] && fc[t*8+:8] <= `ITF_OPT_MAX) o[fc[t*8+:8]] = 1'b1;
    ms = o[17] ? 2'h2 : {1'b0, o[8]};
    an = !o[16] ? 3'h1 : (r == 2'h0) ? 3'h2 : (r == 2'h1) ? 3'h4 : 3'h0;
    return {13'h0, o[1], o[6], o[5:2], o[7] & dc, ms, o[9], o[11], o[15], an};
  endfunction

  // ==========
  // Monitor
  always @(posedge aclk)
  begin
    if (bvalid && bready)
    begin
      x = rq.pop_front();
      `CHK({bresp, 32'h0}, x)
    end
    if (rvalid && rready)
    begin
      x = rq.pop_front();
      `CHK({rresp, rdata}, x)
    end
    if (smp)
    begin
      y = vq.pop_front();
      `CHK(view & y[55:28], y[27:0])
    end
    if (cmd.power_up_reset === 1'b1) pur_n++;
  end

  // ==========
  // Stimulus
  initial
  begin
    void'($urandom(42));
    cyc(10);
    aresetn <= 1'b1;
    for (int r = 0; r < 42; r++)
    begin
      for (int t = 0; t < 8; t++)
      begin
        f[t*8+:8] = (t == 0) ? 8'(r % 21) : 8'($urandom_range(20, 0));
        // A lock terminal turned on by a half-written setup would refuse the next writes
        if (f[t*8+:8] == 8'h0F) f[t*8+:8] = 8'h13;
      end
      p = 8'($urandom);
      act = 8'($urandom);
      dec = 1'($urandom);
      rt = 2'($urandom);
      for (int t = 0; t < 8; t++)
        pe[t] = p[t] && (f[t*8+:8] != `ITF_OPT_RESET);
      wr(`ITF_REG_FUNC_LO, f[31:0], 4'hF, `ITF_RESP_OKAY);
      wr(`ITF_REG_FUNC_HI, f[63:32], 4'hF, `ITF_RESP_OKAY);
      wr(`ITF_REG_POL, {24'h0, p}, 4'hF, `ITF_RESP_OKAY);
      wr(`ITF_REG_ROUTE, {30'h0, rt}, 4'hF, `ITF_RESP_OKAY);
      rd(`ITF_REG_POL, {2'h0, 24'h0, pe});
      decel_in <= dec;
      pins(act ^ pe);
      expv(28'h0007FFF, ref_view(act, f, dec, rt));
      pins(pe);
    end
    // Second reset in mid-run, then defaults and refusals
    lvl <= 8'h00;
    aresetn <= 1'b0;
    cyc(10);
    aresetn <= 1'b1;
    pur_n = 0;
    rd(`ITF_REG_FUNC_LO, {2'h0, `ITF_FUNC_LO_RST});
    rd(`ITF_REG_FUNC_HI, {2'h0, `ITF_FUNC_HI_RST});
    rd(8'h20, {`ITF_RESP_SLVERR, 32'h0});
    wr(`ITF_REG_STATUS, 32'h0, 4'hF, `ITF_RESP_SLVERR);
    wr(`ITF_REG_FUNC_LO, 32'h140E0C12, 4'hF, `ITF_RESP_OKAY);
    wr(`ITF_REG_FUNC_HI, 32'h00000F0D, 4'hF, `ITF_RESP_OKAY);
    wr(`ITF_REG_BYP_DLY, 32'h2, 4'hF, `ITF_RESP_OKAY);
    pins(8'h02);
    expv(FULL, 28'h0860001);
    rd(`ITF_REG_ERROR, {2'h0, 24'h0, `ITF_ERR_OUTSIDE});
    rd(`ITF_REG_STATUS, {2'h0, 32'h00000102});
    pins(8'h00);
    expv(FULL, 28'h0860001);
    pins(8'h01);
    expv(FULL, 28'h0000001);
    pins(8'h00);
    expv(FULL, BASE);
    pins(8'h04);
    expv(FULL, 28'h2000001);
    @(posedge aclk);
    lvl <= 8'h00;
    n = 0;
    while (!cmd.freq_match_req && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= 200) hang();
    `CHK(n >= 13 && n <= 20, 1'b1)
    expv(FULL, 28'h7000001);
    @(posedge aclk);
    freq_match_done <= 1'b1;
    @(posedge aclk);
    freq_match_done <= 1'b0;
    cyc(3);
    expv(FULL, BASE);
    pins(8'h20);
    expv(FULL, 28'h1000009);
    wr(`ITF_REG_JOG, 32'h1234, 4'hF, `ITF_RESP_SLVERR);
    pins(8'h00);
    wr(`ITF_REG_JOG, 32'h1234, 4'hF, `ITF_RESP_OKAY);
    wr(`ITF_REG_JOG, 32'hABCD, 4'h1, `ITF_RESP_OKAY);
    rd(`ITF_REG_JOG, {2'h0, 32'h12CD});
    `CHK(cmd.jog_freq, 16'h12CD)
    run_cmd_in <= 1'b1;
    pins(8'h10);
    pins(8'h11);
    pins(8'h10);
    expv(FULL, 28'h9000001);
    run_cmd_in <= 1'b0;
    cyc(3);
    expv(FULL, BASE);
    @(posedge aclk);
    lvl <= 8'h18;
    n = 0;
    repeat (10)
    begin
      @(posedge aclk);
      n += int'(cmd.three_wire_begin === 1'b1);
    end
    `CHK(n, 1)
    cyc(5);
    `CHK(pur_n, 2)
    print_verdict();
  end
endmodule
